// ---- dv/test_adc_conversion_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
  // ----------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic stop_mode, alt_clk_tick, converter_active, async_osc_en, conv_irq;
  logic [9:0] analog_value;
  logic [4:0] channel_sel;
  int miscompares, tests_run, cycles;
  adc_conversion_control #(.ADDR_W(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .stop_mode(stop_mode), .alt_clk_tick(alt_clk_tick),
    .analog_value(analog_value), .channel_sel(channel_sel), .converter_active(converter_active),
    .async_osc_en(async_osc_en), .conv_irq(conv_irq));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // alternate clock: one tick every second bus clock
  always @(posedge aclk) alt_clk_tick <= aresetn ? ~alt_clk_tick : 1'b0;
  always @(posedge aclk) cycles <= cycles + 1;
  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // handshakes and answers taken at the rising edge that completes them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(posedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [3:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(posedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd = rdata;
      resp = rresp;
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask
  task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
    rdr(a);
    check(name, rd, exp);
  endtask
  // no result reads while converting, to avoid discarded conversions
  task automatic wait_idle(output int n);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (converter_active && n < 3000);
  endtask
  function automatic logic [7:0] exp8(input logic [9:0] v);
    return (v > 10'h3fd) ? 8'hff : 8'((11'(v) + 11'h2) >> 2);
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("scr reset", adc_ctl_pkg::A_SCR, 32'h1f);
    rdchk("clk reset", adc_ctl_pkg::A_CLK, 32'h0);
    rdchk("rh reset", adc_ctl_pkg::A_RH, 32'h0);
    rdchk("rl reset", adc_ctl_pkg::A_RL, 32'h0);
    check("chan reset", channel_sel, 32'h1f);
    check("idle reset", {async_osc_en, converter_active, conv_irq}, 32'h0);
    wr(4'h1, 8'h11);
    check("unmapped wr", resp, adc_ctl_pkg::RESP_SLVERR);
    rdr(4'h1);
    check("unmapped rd", {rd[29:0], resp}, adc_ctl_pkg::RESP_SLVERR);
    rdchk("clk untouched", adc_ctl_pkg::A_CLK, 32'h0);
  endtask
  // clock source, divide, mode and sample length: one row per setting
  task automatic t_timing();
    logic [7:0] cfg [10] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h11, 8'h21, 8'h31, 8'h00, 8'h02, 8'h42};
    int len [10] = '{21, 39, 75, 147, 24, 41, 44, 39, 283, 463};
    logic [9:0] v;
    logic osc;
    int n, tol;
    for (int i = 0; i < 10; i++)
    begin
      v = 10'(i * 113 + 5);
      analog_value <= v;
      tol = cfg[i][1] ? 25 : 6;
      wr(adc_ctl_pkg::A_CLK, cfg[i]);
      check("write okay", resp, adc_ctl_pkg::RESP_OKAY);
      wr(adc_ctl_pkg::A_SCR, 8'h02);
      osc = 1'b0;
      n = 0;
      do
      begin
        @(negedge aclk);
        osc = osc | async_osc_en;
        n++;
      end while (converter_active && n < 3000);
      check("conv time", (n >= len[i] - tol) && (n <= len[i] + tol), 1);
      check("osc running", osc, cfg[i][1]);
      check("osc stopped", async_osc_en, 0);
      check("channel", channel_sel, 32'h02);
      rdchk("flag set", adc_ctl_pkg::A_SCR, 32'h82);
      check("irq off", conv_irq, 0);
      if (cfg[i][4])
      begin
        rdchk("rh 10", adc_ctl_pkg::A_RH, {30'h0, v[9:8]});
        rdchk("rl 10", adc_ctl_pkg::A_RL, {24'h0, v[7:0]});
      end
      else
        rdchk("rl 8", adc_ctl_pkg::A_RL, {24'h0, exp8(v)});
    end
  endtask
  task automatic t_irq();
    int n;
    analog_value <= 10'h3ff;
    wr(adc_ctl_pkg::A_CLK, 8'h01);
    wr(adc_ctl_pkg::A_SCR, 8'h43);
    wait_idle(n);
    repeat (2) @(negedge aclk);
    check("irq on", conv_irq, 1);
    rdchk("flag ie", adc_ctl_pkg::A_SCR, 32'hc3);
    rdchk("rl sat", adc_ctl_pkg::A_RL, 32'hff);
    @(negedge aclk);
    check("irq clear", conv_irq, 0);
    rdchk("flag clear", adc_ctl_pkg::A_SCR, 32'h43);
    wr(adc_ctl_pkg::A_SCR, 8'h1f);
    repeat (5) @(negedge aclk);
    check("no start", converter_active, 0);
    check("chan off", channel_sel, 32'h1f);
  endtask
  task automatic t_abort();
    int n;
    analog_value <= 10'h155;
    wr(adc_ctl_pkg::A_CLK, 8'h11);
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    wait_idle(n);
    wr(adc_ctl_pkg::A_CLK, 8'h1d);
    analog_value <= 10'h0aa;
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    repeat (20) @(posedge aclk);
    wr(adc_ctl_pkg::A_CLK, 8'h1d);
    @(negedge aclk);
    check("cfg abort", converter_active, 0);
    rdchk("rl kept", adc_ctl_pkg::A_RL, 32'h55);
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    repeat (10) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (3) @(negedge aclk);
    check("stop abort", converter_active, 0);
    @(posedge aclk);
    stop_mode <= 1'b0;
    wr(adc_ctl_pkg::A_CLK, 8'h02);
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    stop_mode <= 1'b1;
    wait_idle(n);
    check("stop async", n > 260, 1);
    @(posedge aclk);
    stop_mode <= 1'b0;
    rdchk("rl async", adc_ctl_pkg::A_RL, {24'h0, exp8(10'h0aa)});
    wr(adc_ctl_pkg::A_CLK, 8'h11);
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("reset abort", converter_active, 0);
    rdchk("rl cleared", adc_ctl_pkg::A_RL, 32'h0);
    rdchk("scr cleared", adc_ctl_pkg::A_SCR, 32'h1f);
  endtask
  task automatic t_block();
    int n;
    analog_value <= 10'h2c3;
    wr(adc_ctl_pkg::A_CLK, 8'h11);
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    wait_idle(n);
    rdchk("rh first", adc_ctl_pkg::A_RH, 32'h2);
    analog_value <= 10'h13c;
    wr(adc_ctl_pkg::A_SCR, 8'h02);
    repeat (40) @(negedge aclk);
    check("blocked restart", converter_active, 1);
    rdchk("blocked flag", adc_ctl_pkg::A_SCR, 32'h02);
    rdchk("rl old", adc_ctl_pkg::A_RL, 32'hc3);
    wait_idle(n);
    // low byte last, or the next 10-bit run stays blocked
    rdchk("rh new", adc_ctl_pkg::A_RH, 32'h1);
    rdchk("rl new", adc_ctl_pkg::A_RL, 32'h3c);
  endtask
  task automatic t_cont();
    int k;
    analog_value <= 10'h111;
    wr(adc_ctl_pkg::A_CLK, 8'h11);
    wr(adc_ctl_pkg::A_SCR, 8'h22);
    k = 0;
    do
    begin
      rdr(adc_ctl_pkg::A_SCR);
      k++;
    end while (!rd[7] && k < 60);
    check("cont flag", rd, 32'ha2);
    analog_value <= 10'h2ee;
    rdchk("cont rl 1", adc_ctl_pkg::A_RL, 32'h11);
    repeat (25) @(negedge aclk);
    check("cont running", converter_active, 1);
    rdchk("cont rl 2", adc_ctl_pkg::A_RL, 32'hee);
    wr(adc_ctl_pkg::A_SCR, 8'h1f);
    @(negedge aclk);
    check("cont abort", converter_active, 0);
  endtask
  // ----------------------------------------------------------------
  // main sequence and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_mode} = '0;
    {awaddr, araddr, wdata, analog_value} = '0;
    wstrb = 4'hf;
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    fork
      begin
        t_reset();
        t_timing();
        t_irq();
        t_abort();
        t_block();
        t_cont();
      end
      // scenarios need some 2k cycles; ceiling leaves ample room
      begin
        wait (cycles >= 20000);
        miscompares++;
      end
    join_any
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- shared/adc_ctl_pkg.sv ----
// constants, types and helpers shared by the converter control block
// ----------------------------------------------------------------
// Function
// - async oscillator runs only while converting with it selected, also in stop
// - async oscillator near 2 MHz, or near 1 MHz with low power set
// - both select bits low: converter clock from the alternate clock
// - input select high, async select low: converter clock from bus clock
// - selected clock divided by 1, 2, 4 or 8 per divide field
// - one input converted at a time, chosen by the channel field
// - each conversion is 10-bit or 8-bit per the mode bit
// - software write to status/control starts a conversion unless channel is all ones
// - hardware trigger would start a conversion when selected
// - no hardware trigger here; only writes, continuous restarts and blocked-transfer restarts start conversions
// - continuous mode restarts after each transfer until aborted
// - completion loads results, sets flag, interrupt only if enabled at that moment
// - 8-bit mode rounds to 8 bits, low result only
// - 10-bit with high read but low unread: transfer blocked, flag not set, result lost
// - blocked transfer always starts another conversion
// - abort on status/control write, clock config write, reset, stop without async
// - abort keeps last results; reset clears them
// - reset or abort drops at once into the inactive state, clocks off
// - 8-bit: 18 clocks plus 3 bus first, 38 long; 16 or 36 after
// - 10-bit: 21 clocks plus 3 bus first, 41 long; 19 or 39 after
// - async selected: first conversion adds up to 5 us startup
// - long sample select widens sampling to 23.5 converter clocks
// ----------------------------------------------------------------
package adc_ctl_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] A_SCR = 4'h0;
  localparam logic [3:0] A_CLK = 4'h4;
  localparam logic [3:0] A_RH = 4'h8;
  localparam logic [3:0] A_RL = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] CH_OFF = 5'h1f;
  typedef struct packed {
    logic conversion_complete_flag;
    logic ie;
    logic cont;
    logic [4:0] ch;
  } scr_s;
  typedef struct packed {
    logic lpc;
    logic lsmp;
    logic mode10;
    logic [1:0] div;
    logic acs;
    logic ics;
  } clk_cfg_s;
  localparam scr_s SCR_RST = '{conversion_complete_flag: 1'b0, ie: 1'b0, cont: 1'b0, ch: CH_OFF};
  localparam clk_cfg_s CLK_RST = '0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int ASYNC_HZ = 2_000_000;
  localparam int ASYNC_LP_HZ = 1_000_000;
  localparam logic [4:0] ASYNC_DIV = 5'((CLK_HZ + ASYNC_HZ - 1) / ASYNC_HZ);
  localparam logic [4:0] ASYNC_LP_DIV = 5'((CLK_HZ + ASYNC_LP_HZ - 1) / ASYNC_LP_HZ);
  localparam int STARTUP_NS = 5000;
  localparam logic [6:0] STARTUP_CYC = 7'(STARTUP_NS / CLK_NS);
  localparam logic [1:0] SYNC_BUS = 2'h3;
  localparam int LEN8_FIRST = 18;
  localparam int LEN10_FIRST = 21;
  localparam int LEN_SUB_LESS = 2;
  localparam int SAMPLE_X2_SHORT = 7;
  localparam int SAMPLE_X2_LONG = 47;
  localparam int LONG_EXTRA = (SAMPLE_X2_LONG - SAMPLE_X2_SHORT) / 2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_STARTUP = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SYNC = 4'b1000
  } state_e;
  function automatic logic [5:0] conv_len(input logic mode10, input logic lsmp, input logic first);
    int n;
    n = mode10 ? LEN10_FIRST : LEN8_FIRST;
    if (lsmp)
    begin
      n = n + LONG_EXTRA;
    end
    if (!first)
    begin
      n = n - LEN_SUB_LESS;
    end
    return 6'(n);
  endfunction
endpackage

// ---- src/adc_conversion_control.sv ----
// converter control: clock select/divide, start/abort, result transfer, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // system and analog side
  input wire logic stop_mode,
  input wire logic alt_clk_tick,
  input wire logic [9:0] analog_value,
  output logic [4:0] channel_sel,
  output logic converter_active,
  output logic async_osc_en,
  output logic conv_irq
);
  if (ADDR_W < 4)
  begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  adc_ctl_pkg::scr_s scr_ff;
  adc_ctl_pkg::clk_cfg_s cfg_ff;
  adc_ctl_pkg::state_e state_ff;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0] res_h_ff;
  logic [7:0] res_l_ff;
  logic hi_read_ff, irq_ff, first_ff;
  logic [5:0] cnt_ff;
  logic [6:0] su_cnt_ff;
  logic [1:0] sync_cnt_ff;
  logic [4:0] osc_cnt_ff;
  logic [2:0] div_cnt_ff;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic aw_have, w_have, wr_fire, wr_scr, wr_clk, wr_map;
  logic [ADDR_W-1:0] waddr;
  logic [7:0] wbyte;
  logic wstrb0;
  logic rd_fire, rd_rh, rd_rl;
  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready = !w_got_ff && !bvalid_ff;
  assign arready = !rvalid_ff;
  assign aw_have = aw_got_ff || awvalid;
  assign w_have = w_got_ff || wvalid;
  assign wr_fire = aw_have && w_have && !bvalid_ff;
  assign waddr = aw_got_ff ? awaddr_ff : awaddr;
  assign wbyte = w_got_ff ? wdata_ff : wdata[7:0];
  assign wstrb0 = w_got_ff ? wstrb0_ff : wstrb[0];
  assign wr_map = waddr == ADDR_W'(adc_ctl_pkg::A_SCR) || waddr == ADDR_W'(adc_ctl_pkg::A_CLK)
                  || waddr == ADDR_W'(adc_ctl_pkg::A_RH) || waddr == ADDR_W'(adc_ctl_pkg::A_RL);
  assign wr_scr = wr_fire && wstrb0 && waddr == ADDR_W'(adc_ctl_pkg::A_SCR);
  assign wr_clk = wr_fire && wstrb0 && waddr == ADDR_W'(adc_ctl_pkg::A_CLK);
  assign rd_fire = arvalid && arready;
  assign rd_rh = rd_fire && araddr == ADDR_W'(adc_ctl_pkg::A_RH);
  assign rd_rl = rd_fire && araddr == ADDR_W'(adc_ctl_pkg::A_RL);
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= adc_ctl_pkg::RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? adc_ctl_pkg::RESP_OKAY : adc_ctl_pkg::RESP_SLVERR;
      end
      else
      begin
        if (awvalid && awready)
        begin
          aw_got_ff <= 1'b1;
          awaddr_ff <= awaddr;
        end
        if (wvalid && wready)
        begin
          w_got_ff <= 1'b1;
          wdata_ff <= wdata[7:0];
          wstrb0_ff <= wstrb[0];
        end
        if (bvalid_ff && bready)
          bvalid_ff <= 1'b0;
      end
    end
  end

  // results leave only through these flops, so software always sees bus-domain values
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= adc_ctl_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= adc_ctl_pkg::RESP_OKAY;
      unique case (araddr)
        ADDR_W'(adc_ctl_pkg::A_SCR): rdata_ff <= 32'(scr_ff);
        ADDR_W'(adc_ctl_pkg::A_CLK): rdata_ff <= 32'(cfg_ff);
        ADDR_W'(adc_ctl_pkg::A_RH): rdata_ff <= 32'(res_h_ff);
        ADDR_W'(adc_ctl_pkg::A_RL): rdata_ff <= 32'(res_l_ff);
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= adc_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && rready)
      rvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_ff <= adc_ctl_pkg::CLK_RST;
    else if (wr_clk)
      cfg_ff <= 7'(wbyte);
  end
  assign channel_sel = scr_ff.ch;

  // ----------------------------------------------------------------
  // clock select and divide
  // ----------------------------------------------------------------
  logic abort, busy, osc_tick, src_tick, converter_clock_tick;
  logic [4:0] osc_per;
  logic [2:0] div_mask;
  assign busy = state_ff != adc_ctl_pkg::ST_IDLE;
  assign abort = wr_scr || wr_clk || (stop_mode && !cfg_ff.acs);
  // gated the same cycle the abort is seen, not one edge later
  assign async_osc_en = busy && cfg_ff.acs && !abort;
  assign converter_active = busy;
  assign osc_per = cfg_ff.lpc ? adc_ctl_pkg::ASYNC_LP_DIV : adc_ctl_pkg::ASYNC_DIV;
  assign osc_tick = async_osc_en && osc_cnt_ff == osc_per - 5'h01;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !async_osc_en)
      osc_cnt_ff <= 5'h00;
    else
      osc_cnt_ff <= osc_tick ? 5'h00 : osc_cnt_ff + 5'h01;
  end
  // alternate source must be no faster than aclk: it arrives as a tick enable
  assign src_tick = cfg_ff.acs ? osc_tick : (cfg_ff.ics ? 1'b1 : alt_clk_tick);
  assign div_mask = 3'((4'h1 << cfg_ff.div) - 4'h1);
  assign converter_clock_tick = state_ff == adc_ctl_pkg::ST_CONV && !abort && src_tick
                     && (div_cnt_ff & div_mask) == div_mask;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || state_ff != adc_ctl_pkg::ST_CONV || abort)
      div_cnt_ff <= 3'h0;
    else if (src_tick)
      div_cnt_ff <= converter_clock_tick ? 3'h0 : div_cnt_ff + 3'h1;
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  logic start_sw, conv_end, xfer, blocked;
  logic [5:0] len;
  logic [10:0] rnd;
  // no hardware trigger source exists, only writes and restarts start
  assign start_sw = wr_scr && wbyte[4:0] != adc_ctl_pkg::CH_OFF;
  assign len = adc_ctl_pkg::conv_len(cfg_ff.mode10, cfg_ff.lsmp, first_ff);
  assign conv_end = converter_clock_tick && cnt_ff == len - 6'h01;
  assign xfer = !abort && ((state_ff == adc_ctl_pkg::ST_SYNC && sync_cnt_ff == adc_ctl_pkg::SYNC_BUS - 2'h1)
                || (conv_end && !first_ff));
  assign blocked = cfg_ff.mode10 && hi_read_ff;
  assign rnd = 11'(analog_value) + 11'h002;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= adc_ctl_pkg::ST_IDLE;
      first_ff <= 1'b1;
      cnt_ff <= 6'h00;
      su_cnt_ff <= 7'h00;
      sync_cnt_ff <= 2'h0;
    end
    else if (start_sw || (xfer && blocked))
    begin
      state_ff <= cfg_ff.acs ? adc_ctl_pkg::ST_STARTUP : adc_ctl_pkg::ST_CONV;
      first_ff <= 1'b1;
      cnt_ff <= 6'h00;
      su_cnt_ff <= 7'h00;
      sync_cnt_ff <= 2'h0;
    end
    else if (abort)
      state_ff <= adc_ctl_pkg::ST_IDLE;
    else if (xfer)
    begin
      state_ff <= scr_ff.cont ? adc_ctl_pkg::ST_CONV : adc_ctl_pkg::ST_IDLE;
      first_ff <= 1'b0;
      cnt_ff <= 6'h00;
    end
    else
    begin
      unique case (state_ff)
        adc_ctl_pkg::ST_IDLE: cnt_ff <= 6'h00;
        adc_ctl_pkg::ST_STARTUP:
        begin
          su_cnt_ff <= su_cnt_ff + 7'h01;
          if (su_cnt_ff == adc_ctl_pkg::STARTUP_CYC - 7'h01)
            state_ff <= adc_ctl_pkg::ST_CONV;
        end
        adc_ctl_pkg::ST_CONV:
        begin
          if (conv_end)
            state_ff <= adc_ctl_pkg::ST_SYNC;
          else if (converter_clock_tick)
            cnt_ff <= cnt_ff + 6'h01;
        end
        adc_ctl_pkg::ST_SYNC: sync_cnt_ff <= sync_cnt_ff + 2'h1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // results, completion flag, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_h_ff <= 2'h0;
      res_l_ff <= 8'h00;
    end
    else if (xfer && !blocked)
    begin
      if (cfg_ff.mode10)
      begin
        res_h_ff <= analog_value[9:8];
        res_l_ff <= analog_value[7:0];
      end
      else
      begin
        res_h_ff <= 2'h0;
        res_l_ff <= rnd[10] ? 8'hff : rnd[9:2];
      end
    end
  end

  // a high-byte read blocks 10-bit transfers until the low byte is read
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rd_rl)
      hi_read_ff <= 1'b0;
    else if (rd_rh)
      hi_read_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scr_ff <= adc_ctl_pkg::SCR_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_scr)
      begin
        scr_ff.ch <= wbyte[4:0];
        scr_ff.cont <= wbyte[5];
        scr_ff.ie <= wbyte[6];
      end
      // a new completion wins over a clear in the same cycle
      if (xfer && !blocked)
      begin
        scr_ff.conversion_complete_flag <= 1'b1;
        irq_ff <= scr_ff.ie;
      end
      else if (wr_scr || rd_rl)
      begin
        scr_ff.conversion_complete_flag <= 1'b0;
        irq_ff <= 1'b0;
      end
    end
  end
  assign conv_irq = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_sw_start_go: assert property (start_sw |=> busy && first_ff)
    else $error("software start did not begin a conversion");
  a_ch_off_idle: assert property (wr_scr && !start_sw |=> !busy)
    else $error("all-ones channel write left converter running");
  a_clk_wr_abort: assert property (wr_clk && !xfer |=> state_ff == adc_ctl_pkg::ST_IDLE)
    else $error("clock config write did not abort");
  a_stop_abort_now: assert property (stop_mode && !cfg_ff.acs |-> !async_osc_en && !converter_clock_tick)
    else $error("clocks still running in stop without async clock");
  a_block_keeps: assert property (xfer && blocked |=> $stable(res_l_ff) && !$rose(scr_ff.conversion_complete_flag) && busy)
    else $error("blocked transfer changed results or stopped");
  a_irq_follows: assert property ($rose(scr_ff.conversion_complete_flag) |-> irq_ff == $past(scr_ff.ie))
    else $error("interrupt does not follow enable at completion");
  a_len_exact: assert property (conv_end |-> len inside {6'h10, 6'h12, 6'h13, 6'h15, 6'h24, 6'h26, 6'h27, 6'h29})
    else $error("conversion length out of table");
  a_sync_three: assert property (conv_end && first_ff && !abort ##1 !abort [*3] |-> xfer || $past(xfer))
    else $error("first result not transferred after three bus clocks");
  a_eight_low: assert property (xfer && !blocked && !cfg_ff.mode10 |=> res_h_ff == 2'h0)
    else $error("8-bit result touched high byte");
  a_osc_only_busy: assert property (async_osc_en |-> busy && cfg_ff.acs)
    else $error("async oscillator on while idle");
  c_single_done: cover property (xfer && !blocked && !scr_ff.cont);
  c_cont_next: cover property (xfer && scr_ff.cont ##[1:200] xfer);
  c_blocked: cover property (xfer && blocked);
  c_async_start: cover property (state_ff == adc_ctl_pkg::ST_STARTUP ##[1:200] state_ff == adc_ctl_pkg::ST_CONV);
endmodule
`default_nettype wire
